// ### rtl/dbsp_port.sv
// Device side of the burst-of-four double-data-rate SRAM port
// Function
// - Bursts are cut off at clock stop; read and echo outputs hold, lock drops
// - Read or write on next K edge ignored
// - Write after read ignores the read select
// - Write beats at K t+1 and t+2
// - Four lanes: each low enable writes its byte
// - Byte enables sampled on every beat edge
// - Byte enables act only inside a write
// - Read select high at an idle K edge: read outputs high impedance
// - Read beats alternate from next K-complement edge
// - Enable lanes map to nine-bit data slices
`timescale 1ns/1ns
module dbsp_port import dbsp_pkg::*; #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 8,
    parameter int STOP_CYCLES = DBSP_STOP_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic k_clock,
    input wire logic k_clock_n,
    input wire logic read_select_n,
    input wire logic write_select_n,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic byte_enable_lane0_n,
    input wire logic byte_enable_lane1_n,
    input wire logic byte_enable_lane2_n,
    input wire logic byte_enable_lane3_n,
    input wire logic byte_enable_single_n,
    output logic [DATA_W-1:0] read_data,
    output logic read_data_oe,
    output logic echo_clock_true,
    output logic echo_clock_comp,
    output logic dll_locked,
    output logic clock_stopped
);

    localparam int LANES = DATA_W / DBSP_LANE_W;
    localparam int IN_W = DBSP_CTRL_W + ADDR_W + DATA_W;
    localparam logic [IN_W-1:0] IN_RST = {DBSP_CTRL_RST, {(ADDR_W + DATA_W){1'b0}}};
    localparam int DEPTH = (1 << ADDR_W) * DBSP_BEATS;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] step_beat(input dbsp_step_e s);
        case (s)
            DBSP_S1: step_beat = 2'h0;
            DBSP_S2: step_beat = 2'h1;
            DBSP_S3: step_beat = 2'h2;
            DBSP_S4: step_beat = 2'h3;
            default: step_beat = 2'h0;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] lane_mask(input logic [3:0] be_n);
        lane_mask = '0;
        for (int i = 0; i < LANES; i++) begin
            lane_mask[i*DBSP_LANE_W +: DBSP_LANE_W] = {DBSP_LANE_W{~be_n[i]}};
        end
    endfunction

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    logic [IN_W-1:0] pins_f;
    dbsp_sync #(.W(IN_W), .RST_VAL(IN_RST)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .din({k_clock, k_clock_n, 2'b11, read_select_n, write_select_n, byte_enable_lane3_n,
              byte_enable_lane2_n, byte_enable_lane1_n, byte_enable_lane0_n, byte_enable_single_n,
              1'b1, address, write_data}),
        .dout(pins_f)
    );

    wire k_f = pins_f[IN_W-1];
    wire kn_f = pins_f[IN_W-2];
    wire rsel_n = pins_f[IN_W-5];
    wire wsel_n = pins_f[IN_W-6];
    wire [3:0] lanes_n = pins_f[IN_W-7 -: 4];
    wire single_n = pins_f[IN_W-11];
    wire [ADDR_W-1:0] addr_f = pins_f[DATA_W +: ADDR_W];
    wire [DATA_W-1:0] data_f = pins_f[DATA_W-1:0];

    // Per-beat enables of the chosen organisation
    wire [3:0] be_n = (LANES == 1) ? {3'b111, single_n} :
                      (LANES == 2) ? {2'b11, lanes_n[1:0]} :
                      lanes_n;

    logic k_prev;
    logic kn_prev;
    wire k_rise = k_f & ~k_prev;
    wire kn_rise = kn_f & ~kn_prev;

    // ------------------------------------------------------------
    // Clock stop and DLL lock tracking
    // ------------------------------------------------------------
    logic [15:0] idle_cnt;
    logic [10:0] lock_cnt;
    wire any_edge = k_rise | kn_rise;
    wire stop_now = (idle_cnt >= 16'(STOP_CYCLES)) && !any_edge;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            k_prev <= 1'b0;
            kn_prev <= 1'b1;
            idle_cnt <= '0;
            clock_stopped <= 1'b1;
            lock_cnt <= '0;
            echo_clock_true <= 1'b0;
            echo_clock_comp <= 1'b0;
        end else begin
            k_prev <= k_f;
            kn_prev <= kn_f;
            idle_cnt <= any_edge ? '0 : (stop_now ? idle_cnt : idle_cnt + 16'h1);
            clock_stopped <= stop_now;
            // Lock count restarts after every stop, the DLL reset
            if (stop_now)
                lock_cnt <= '0;
            else if (k_rise && lock_cnt != 11'(DBSP_DLL_LOCK_CYCLES))
                lock_cnt <= lock_cnt + 11'h1;
            echo_clock_true <= k_f;
            echo_clock_comp <= kn_f;
        end
    end

    assign dll_locked = (lock_cnt == 11'(DBSP_DLL_LOCK_CYCLES));

    // ------------------------------------------------------------
    // Write sequencing
    // ------------------------------------------------------------
    dbsp_step_e wr_step;
    dbsp_step_e next_wr_step;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] wr_queue_addr;
    logic wr_queued;
    logic [DATA_W-1:0] mem [0:DEPTH-1];

    // Read select is not looked at; second write at t+1 is refused
    wire wr_accept = k_rise && !wsel_n && (wr_step == DBSP_IDLE || wr_step == DBSP_S3);
    wire mem_we = (k_rise && (wr_step == DBSP_S1 || wr_step == DBSP_S3)) ||
                  (kn_rise && (wr_step == DBSP_S2 || wr_step == DBSP_S4));
    wire [DATA_W-1:0] wr_mask = lane_mask(be_n);
    wire [ADDR_W+1:0] wr_idx = {wr_addr, step_beat(wr_step)};

    always_comb begin
        next_wr_step = wr_step;
        case (wr_step)
            DBSP_IDLE: if (wr_accept) next_wr_step = DBSP_S1;
            DBSP_S1: if (k_rise) next_wr_step = DBSP_S2;
            DBSP_S2: if (kn_rise) next_wr_step = DBSP_S3;
            DBSP_S3: if (k_rise) next_wr_step = DBSP_S4;
            DBSP_S4: if (kn_rise) next_wr_step = wr_queued ? DBSP_S1 : DBSP_IDLE;
            default: next_wr_step = DBSP_IDLE;
        endcase
        if (stop_now)
            next_wr_step = DBSP_IDLE;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wr_step <= DBSP_IDLE;
            wr_addr <= '0;
            wr_queue_addr <= '0;
            wr_queued <= 1'b0;
        end else begin
            wr_step <= next_wr_step;
            if (wr_accept && wr_step == DBSP_IDLE)
                wr_addr <= addr_f;
            if (wr_accept && wr_step == DBSP_S3) begin
                wr_queue_addr <= addr_f;
                wr_queued <= 1'b1;
            end else if ((kn_rise && wr_step == DBSP_S4) || stop_now) begin
                wr_addr <= wr_queue_addr;
                wr_queued <= 1'b0;
            end
        end
    end

    // Only the enabled lanes of a beat change
    always_ff @(posedge clock) begin
        if (mem_we)
            mem[wr_idx] <= (mem[wr_idx] & ~wr_mask) | (data_f & wr_mask);
    end

    // ------------------------------------------------------------
    // Read sequencing
    // ------------------------------------------------------------
    dbsp_step_e rd_step;
    dbsp_step_e next_rd_step;
    logic [ADDR_W-1:0] rd_addr;

    wire rd_accept = k_rise && !rsel_n && (rd_step == DBSP_IDLE || rd_step == DBSP_S4);
    wire rd_fire = (kn_rise && (rd_step == DBSP_S1 || rd_step == DBSP_S3)) ||
                   (k_rise && (rd_step == DBSP_S2 || rd_step == DBSP_S4));
    wire rd_deselect = k_rise && rd_step == DBSP_IDLE && !rd_accept;
    wire [ADDR_W+1:0] rd_idx = {rd_addr, step_beat(rd_step)};

    always_comb begin
        next_rd_step = rd_step;
        case (rd_step)
            DBSP_IDLE: if (rd_accept) next_rd_step = DBSP_S1;
            DBSP_S1: if (kn_rise) next_rd_step = DBSP_S2;
            DBSP_S2: if (k_rise) next_rd_step = DBSP_S3;
            DBSP_S3: if (kn_rise) next_rd_step = DBSP_S4;
            DBSP_S4: if (k_rise) next_rd_step = rd_accept ? DBSP_S1 : DBSP_IDLE;
            default: next_rd_step = DBSP_IDLE;
        endcase
        if (stop_now)
            next_rd_step = DBSP_IDLE;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_step <= DBSP_IDLE;
            rd_addr <= '0;
            read_data <= '0;
            read_data_oe <= 1'b0;
        end else begin
            rd_step <= next_rd_step;
            if (rd_accept)
                rd_addr <= addr_f;
            if (rd_fire) begin
                read_data <= mem[rd_idx];
                read_data_oe <= 1'b1;
            end else if (rd_deselect) begin
                read_data_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_rd_start;
        k_rise && !rsel_n && rd_step == DBSP_IDLE;
    endsequence

    sequence s_first_beat;
        rd_step == DBSP_S1 && kn_rise;
    endsequence

    a_rd_second_ignored: assert property (@(posedge clock) disable iff (!reset_n)
        k_rise && rd_step == DBSP_S2 |=> rd_step == DBSP_S3)
        else $error("read request at t+1 was not ignored");

    a_wr_second_ignored: assert property (@(posedge clock) disable iff (!reset_n)
        k_rise && wr_step == DBSP_S1 |=> wr_step == DBSP_S2 && !wr_queued)
        else $error("write request at t+1 was not ignored");

    a_wr_accept_step: assert property (@(posedge clock) disable iff (!reset_n)
        k_rise && !wsel_n && wr_step == DBSP_IDLE |=> wr_step == DBSP_S1 && wr_addr == $past(addr_f))
        else $error("write request not taken");

    a_rd_accept_step: assert property (@(posedge clock) disable iff (!reset_n)
        s_rd_start |=> rd_step == DBSP_S1 && rd_addr == $past(addr_f))
        else $error("read request not taken");

    a_rd_first_beat: assert property (@(posedge clock) disable iff (!reset_n)
        s_rd_start |=> ##[0:16] s_first_beat ##1 (read_data_oe && rd_step == DBSP_S2))
        else $error("first read beat not driven on the K-complement edge");

    a_deselect_hiz: assert property (@(posedge clock) disable iff (!reset_n)
        k_rise && rsel_n && wsel_n && rd_step == DBSP_IDLE |=> !read_data_oe)
        else $error("read outputs not released at deselect");

    a_we_in_write: assert property (@(posedge clock) disable iff (!reset_n)
        mem_we |-> wr_step != DBSP_IDLE && (k_rise || kn_rise))
        else $error("array written outside a write burst");

    a_lane_write: assert property (@(posedge clock) disable iff (!reset_n)
        mem_we |=> (mem[$past(wr_idx)] & $past(wr_mask)) == ($past(data_f) & $past(wr_mask)))
        else $error("enabled lanes of a write beat not stored");

    a_stop_hold: assert property (@(posedge clock) disable iff (!reset_n)
        clock_stopped && !any_edge |=> $stable(read_data) && rd_step == DBSP_IDLE && wr_step == DBSP_IDLE)
        else $error("state moved while the clock was stopped");

    a_dll_relock: assert property (@(posedge clock) disable iff (!reset_n)
        stop_now |=> !dll_locked ##1 !dll_locked)
        else $error("lock claimed right after a clock stop");

endmodule

// ### rtl/dbsp_pkg.sv
// Shared constants and types of the burst-of-four double-data-rate SRAM port
package dbsp_pkg;

    // ------------------------------------------------------------
    // Burst sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DBSP_IDLE = 3'h0,
        DBSP_S1 = 3'h1,
        DBSP_S2 = 3'h3,
        DBSP_S3 = 3'h2,
        DBSP_S4 = 3'h6
    } dbsp_step_e;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int DBSP_LANE_W = 9;
    localparam int DBSP_BEATS = 4;
    localparam int DBSP_DLL_LOCK_CYCLES = 1024;
    localparam int DBSP_STOP_CYCLES = 16;
    localparam int DBSP_CTRL_W = 12;
    localparam logic [DBSP_CTRL_W-1:0] DBSP_CTRL_RST = 12'h7ff;

endpackage

// ### rtl/dbsp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dbsp_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire [W-1:0] agree = ~(s2 ^ s3);

    // A bit moves only once stages two and three agree
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= (s3 & agree) | (dout & ~agree);
        end
    end

endmodule

// ### tb/dbsp_ctl_model.sv
// Memory controller model: makes K and K#, requests and write beats
`timescale 1ns/1ns
module dbsp_ctl_model (
    output logic k_clock,
    output logic k_clock_n,
    output logic read_select_n,
    output logic write_select_n,
    output logic [7:0] address,
    output logic [35:0] write_data,
    output logic [3:0] lane_n,
    input wire logic [35:0] read_data,
    input wire logic read_data_oe
);
    initial begin
        {k_clock, k_clock_n, read_select_n, write_select_n} = 4'h7;
        address = 8'h00;
        write_data = 36'h0;
        lane_n = 4'hf;
    end
    // One 125 ns K period; K stands low between calls, too short for a clock stop when calls run back to back
    // Fixed frequency, so one lock after each stop suffices
    task automatic cycle(input logic rs, ws, input logic [7:0] a, input logic [35:0] d0, d1,
                         input logic [3:0] b0, b1, output logic [35:0] qa, qb, output logic oa, ob);
        #1 {read_select_n, write_select_n, address, write_data, lane_n} = {rs, ws, a, d0, b0};
        #31 {k_clock, k_clock_n} = 2'b10;
        #30 {qa, oa} = {read_data, read_data_oe};
        // Selects go high after every K edge, so a new request follows an idle sample
        #1 {read_select_n, write_select_n, address, write_data, lane_n} = {2'b11, ~a, d1, b1};
        #31 {k_clock, k_clock_n} = 2'b01;
        #30 {qb, ob} = {read_data, read_data_oe};
        #1;
    endtask
endmodule

// ### tb/dbsp_port_tb.sv
// Self-checking bench for the burst-of-four SRAM port
`timescale 1ns/1ns
module dbsp_port_tb import dbsp_pkg::*; ;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic k, kn, rs_n, ws_n, oe, echo_t, echo_c, locked, stopped, oa, ob;
    logic [7:0] addr;
    logic [3:0] ln;
    logic [35:0] wd, rd, qa, qb;
    logic [35:0] d [4];
    logic [35:0] exp_mem [256][4];
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    localparam logic [15:0] ROW_BE [6] = '{16'h0000, 16'heeee, 16'hdddd, 16'h3333, 16'hffff, 16'h3de0};
    always #5 clock = ~clock;
    dbsp_port #(.DATA_W(36), .ADDR_W(8), .STOP_CYCLES(16)) dbsp_port_i (.clock(clock), .reset_n(reset_n),
        .k_clock(k), .k_clock_n(kn), .read_select_n(rs_n), .write_select_n(ws_n), .address(addr),
        .write_data(wd), .byte_enable_lane0_n(ln[0]), .byte_enable_lane1_n(ln[1]),
        .byte_enable_lane2_n(ln[2]), .byte_enable_lane3_n(ln[3]), .byte_enable_single_n(ln[0]),
        .read_data(rd), .read_data_oe(oe), .echo_clock_true(echo_t), .echo_clock_comp(echo_c),
        .dll_locked(locked), .clock_stopped(stopped));
    dbsp_ctl_model dbsp_ctl_model_i (.k_clock(k), .k_clock_n(kn), .read_select_n(rs_n),
        .write_select_n(ws_n), .address(addr), .write_data(wd), .lane_n(ln), .read_data(rd),
        .read_data_oe(oe));
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 35000) begin
            mismatches++;
            finish_test();
        end
    end
    task automatic check_data(input string name, input logic [35:0] e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic check_bit(input string name, input logic e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask
    task automatic cyc(input logic r, w, input logic [7:0] a, input logic [35:0] d0, d1, input logic [3:0] b0, b1);
        dbsp_ctl_model_i.cycle(r, w, a, d0, d1, b0, b1, qa, qb, oa, ob);
    endtask
    // Idle cycles hold enables low with junk data
    task automatic idle();
        cyc(1'b1, 1'b1, 8'h00, 36'haaaaaaaaa, 36'h555555555, 4'h0, 4'h0);
    endtask
    task automatic prep(input logic [7:0] a, input logic [35:0] f, input logic [15:0] be);
        for (int k = 0; k < DBSP_BEATS; k++) begin
            d[k] = f ^ {4{a[6:0], 2'(k)}};
            for (int l = 0; l < 4; l++)
                if (!be[4*k+l]) exp_mem[a][k][DBSP_LANE_W*l+:DBSP_LANE_W] = d[k][DBSP_LANE_W*l+:DBSP_LANE_W];
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [35:0] f, input logic [15:0] be);
        prep(a, f, be);
        cyc(1'b1, 1'b0, a, 36'h0, 36'h0, 4'h0, 4'h0);
        cyc(1'b1, 1'b1, a, d[0], d[1], be[3:0], be[7:4]);
        cyc(1'b1, 1'b1, a, d[2], d[3], be[11:8], be[15:12]);
    endtask
    task automatic rd_chk(input logic [7:0] a);
        cyc(1'b0, 1'b1, a, 36'h0, 36'h0, 4'hf, 4'hf);
        idle();
        check_bit("read_data_oe", 1'b1, oa);
        check_data("beat0", exp_mem[a][0], qa);
        check_data("beat1", exp_mem[a][1], qb);
        idle();
        check_data("beat2", exp_mem[a][2], qa);
        check_data("beat3", exp_mem[a][3], qb);
    endtask
    // Controller waits for lock before relying on reads
    task automatic warm();
        repeat (DBSP_DLL_LOCK_CYCLES - 1) idle();
        check_bit("dll_locked early", 1'b0, locked);
        idle();
        check_bit("dll_locked", 1'b1, locked);
    endtask
    initial begin
        repeat (10) @(negedge clock);
        check_bit("clock_stopped reset", 1'b1, stopped);
        check_bit("read_data_oe reset", 1'b0, oe);
        check_data("read_data reset", 36'h0, rd);
        reset_n = 1'b1;
        repeat (10) @(negedge clock);
        warm();
        foreach (ROW_BE[i]) begin
            wr(8'(8'h10 + i), 36'h0, 16'h0000);
            wr(8'(8'h10 + i), 36'hfffffffff, ROW_BE[i]);
            rd_chk(8'(8'h10 + i));
            idle();
            check_bit("read_data_oe idle", 1'b0, ob);
            $display("row %0d done", i);
        end
        // Read, then write with read select still low on the next edge
        prep(8'h20, 36'h123456789, 16'h0000);
        cyc(1'b0, 1'b1, 8'h15, 36'h0, 36'h0, 4'hf, 4'hf);
        cyc(1'b0, 1'b0, 8'h20, 36'h0, 36'h0, 4'hf, 4'hf);
        check_data("beat0 rw", exp_mem[8'h15][0], qa);
        check_data("beat1 rw", exp_mem[8'h15][1], qb);
        cyc(1'b1, 1'b1, 8'h00, d[0], d[1], 4'h0, 4'h0);
        check_data("beat2 rw", exp_mem[8'h15][2], qa);
        check_data("beat3 rw", exp_mem[8'h15][3], qb);
        cyc(1'b1, 1'b1, 8'h00, d[2], d[3], 4'h0, 4'h0);
        check_bit("read_data_oe rw", 1'b0, ob);
        rd_chk(8'h20);
        $display("read then write done");
        // Second write on the next edge is dropped
        prep(8'h14, 36'h0f0f0f0f0, 16'h0000);
        cyc(1'b1, 1'b0, 8'h14, 36'h0, 36'h0, 4'h0, 4'h0);
        cyc(1'b1, 1'b0, 8'h13, d[0], d[1], 4'h0, 4'h0);
        cyc(1'b1, 1'b1, 8'h00, d[2], d[3], 4'h0, 4'h0);
        idle();
        rd_chk(8'h13);
        rd_chk(8'h14);
        $display("write pair done");
        // Stop K well beyond the 16-cycle (160 ns) stop count after a finished burst
        #400;
        check_data("read_data hold", exp_mem[8'h14][3], rd);
        check_bit("clock_stopped", 1'b1, stopped);
        check_bit("echo_clock_true", 1'b0, echo_t);
        check_bit("echo_clock_comp", 1'b1, echo_c);
        warm();
        rd_chk(8'h12);
        $display("clock stop done");
        finish_test();
    end
endmodule
